/* File: shared/scfg_pkg.sv */
// Constants and carrier types for the stack and strap priority config block
// Operation
// - Bits 7:4 of stack arrangement always show strapped count and position.
// - Position field 3:2 codes primary, first, second, third secondary.
// - Count field 1:0 codes one to four devices including primary.
// - Position and count fields load from latched strap results.
// - Stack arrangement answers a single byte read at code d6.
// - Priority word is written and read as a word at code d8.
// - Priority bit zero favours stored values, one favours strap values.
// - Store updates strap-loaded commands only if they were written first.
// - Changed priority bits act only after store and power cycle.
// - Stack bit 15 low forces primary single phase, high uses straps.
// - Priority bits 14:12 read zero and ignore writes.
// - Soft-start bit 11 selects stored rise time or strap result.
// - Fault bit 10 selects stored fault responses or strap result.
// - Bits 9,6,5,4,3,2 select stored values or strap result.
// - Vout bit 0 selects strap choice, ignored with external divider.
package scfg_pkg;

  localparam logic [7:0]  CMD_STACK      = 8'hd6;
  localparam logic [7:0]  CMD_PRIORITY   = 8'hd8;
  // Bits that exist in the priority word; the rest read as zero
  localparam logic [15:0] PRIO_MASK      = 16'h8e7d;
  localparam logic [15:0] PRIO_RESET     = 16'h0000;
  localparam logic [3:0]  STACK_RESET    = 4'h0;
  // Primary, single phase: position 00b, count 00b
  localparam logic [3:0]  STACK_PRIMARY  = 4'h0;
  localparam int          STK_POS_HI     = 3;
  localparam int          STK_POS_LO     = 2;
  localparam int          STK_NUM_HI     = 1;
  localparam int          STK_NUM_LO     = 0;

  // Strap-selectable functions, index into the use-strap vector
  localparam int FUNC_N       = 10;
  localparam int F_STACK      = 0;
  localparam int F_SOFTSTART  = 1;
  localparam int F_FAULT      = 2;
  localparam int F_BUS_ADDR   = 3;
  localparam int F_LIGHT_LOAD = 4;
  localparam int F_SW_FREQ    = 5;
  localparam int F_RAMP       = 6;
  localparam int F_LOOP_GAIN  = 7;
  localparam int F_CUR_LIMIT  = 8;
  localparam int F_VOUT_SEL   = 9;
  // Priority word bit that governs each function, same order as above
  localparam int FUNC_BIT [FUNC_N] = '{15, 11, 10, 9, 6, 5, 4, 3, 2, 0};

  typedef struct packed {
    logic [1:0] stack_count;
    logic [1:0] stack_position;
  } scfg_strap_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        word;
    logic [7:0]  code;
    logic [15:0] data;
  } scfg_req_t;

  typedef struct packed {
    logic        valid;
    logic        ack;
    logic [15:0] data;
  } scfg_rsp_t;

endpackage

/* File: core/scfg_strap_latch.sv */
// One-shot capture of strap pins and the stored priority word after reset
`timescale 1ns/1ps
module scfg_strap_latch
(
  input  wire logic                  i_clock,
  input  wire logic                  i_rst_n,
  input  wire scfg_pkg::scfg_strap_t i_strap,
  input  wire logic [15:0]           i_nvm_priority,
  output logic                       o_done,
  output scfg_pkg::scfg_strap_t      o_strap,
  output logic [15:0]                o_active_priority
);

  logic                  done_q;
  logic                  done_d;
  scfg_pkg::scfg_strap_t strap_q;
  scfg_pkg::scfg_strap_t strap_d;
  logic [15:0]           act_q;
  logic [15:0]           act_d;

  // Capture once; later changes of pins or registers never re-trigger it
  always_comb
  begin
    done_d  = done_q;
    strap_d = strap_q;
    act_d   = act_q;
    if (!done_q)
    begin
      done_d  = 1'b1;
      strap_d = i_strap;
      act_d   = i_nvm_priority & scfg_pkg::PRIO_MASK;
    end
  end

  // Reset takes constants only; the pins are read after release
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      done_q  <= 1'b0;
      strap_q <= '0;
      act_q   <= scfg_pkg::PRIO_RESET;
    end
    else
    begin
      done_q  <= done_d;
      strap_q <= strap_d;
      act_q   <= act_d;
    end
  end

  assign o_done            = done_q;
  assign o_strap           = strap_q;
  assign o_active_priority = act_q;

endmodule // scfg_strap_latch

/* File: core/scfg_top.sv */
// Stack arrangement and strap priority registers with store handling
`timescale 1ns/1ps
module scfg_top
(
  input  wire logic                  i_clock,
  input  wire logic                  i_rst_n,
  input  wire scfg_pkg::scfg_strap_t i_strap,
  input  wire logic [15:0]           i_nvm_priority,
  input  wire logic                  i_ext_divider,
  input  wire scfg_pkg::scfg_req_t   i_req,
  input  wire logic                  i_store,
  input  wire logic [9:0]            i_func_written,
  output scfg_pkg::scfg_rsp_t        o_rsp,
  output logic                       o_ready,
  output logic [9:0]                 o_use_strap,
  output logic [3:0]                 o_stack_role,
  output logic                       o_store_valid,
  output logic [15:0]                o_store_priority,
  output logic [3:0]                 o_store_stack,
  output logic [9:0]                 o_store_mask
);

  logic                  latch_done;
  scfg_pkg::scfg_strap_t strap;
  logic [15:0]           act;

  scfg_strap_latch u_latch
  (
    .i_clock           (i_clock),
    .i_rst_n           (i_rst_n),
    .i_strap           (i_strap),
    .i_nvm_priority    (i_nvm_priority),
    .o_done            (latch_done),
    .o_strap           (strap),
    .o_active_priority (act)
  );

  logic                loaded_q;
  logic                loaded_d;
  logic [3:0]          stk_q;
  logic [3:0]          stk_d;
  logic [15:0]         prio_q;
  logic [15:0]         prio_d;
  logic [9:0]          written_q;
  logic [9:0]          written_d;
  scfg_pkg::scfg_rsp_t rsp_q;
  scfg_pkg::scfg_rsp_t rsp_d;
  logic                store_q;
  logic                store_d;
  logic [15:0]         st_prio_q;
  logic [15:0]         st_prio_d;
  logic [3:0]          st_stk_q;
  logic [3:0]          st_stk_d;
  logic [9:0]          st_mask_q;
  logic [9:0]          st_mask_d;
  logic [9:0]          use_q;
  logic [9:0]          use_d;
  logic [3:0]          role_q;
  logic [3:0]          role_d;
  logic [3:0]          load_stk;
  logic [9:0]          sel_raw;
  logic                take;
  logic                hit_stack;
  logic                hit_prio;

  // Per-function strap selection from the priority latched at power-on
  genvar g;
  generate
    for (g = 0; g < scfg_pkg::FUNC_N; g++)
    begin : g_sel
      assign sel_raw[g] = act[scfg_pkg::FUNC_BIT[g]];
    end
  endgenerate

  assign take      = i_req.valid && loaded_q;
  assign hit_stack = i_req.code == scfg_pkg::CMD_STACK;
  assign hit_prio  = i_req.code == scfg_pkg::CMD_PRIORITY;

  // Selection outputs; only the power-on copy counts, not live writes
  always_comb
  begin
    use_d  = sel_raw;
    use_d[scfg_pkg::F_VOUT_SEL] = sel_raw[scfg_pkg::F_VOUT_SEL]
                                  && !i_ext_divider;
    role_d = act[scfg_pkg::FUNC_BIT[scfg_pkg::F_STACK]] ? strap
                                   : scfg_pkg::STACK_PRIMARY;
    // Register puts position above count, the strap copy the other way
    load_stk = scfg_pkg::STACK_PRIMARY;
    if (act[scfg_pkg::FUNC_BIT[scfg_pkg::F_STACK]])
    begin
      load_stk[scfg_pkg::STK_POS_HI:scfg_pkg::STK_POS_LO] =
        strap.stack_position;
      load_stk[scfg_pkg::STK_NUM_HI:scfg_pkg::STK_NUM_LO] =
        strap.stack_count;
    end
  end

  // Register file and command handling
  always_comb
  begin
    loaded_d  = loaded_q;
    stk_d     = stk_q;
    prio_d    = prio_q;
    written_d = written_q | i_func_written;
    rsp_d     = '0;
    if (latch_done && !loaded_q)
    begin
      // Fields start from the straps, or primary single phase
      loaded_d = 1'b1;
      stk_d    = load_stk;
      prio_d   = act;
    end
    if (take)
    begin
      rsp_d.valid = 1'b1;
      if (hit_stack && !i_req.word)
      begin
        rsp_d.ack = 1'b1;
        if (i_req.write)
        begin
          stk_d = i_req.data[scfg_pkg::STK_POS_HI:scfg_pkg::STK_NUM_LO];
          written_d[scfg_pkg::F_STACK] = 1'b1;
        end
        else
        begin
          // Upper nibble keeps the strap copy whatever the low nibble holds
          rsp_d.data = {8'h00, strap, stk_q};
        end
      end
      else if (hit_prio && i_req.word)
      begin
        rsp_d.ack = 1'b1;
        if (i_req.write)
        begin
          // Takes effect only after store and power cycle
          prio_d = i_req.data & scfg_pkg::PRIO_MASK;
        end
        else
        begin
          rsp_d.data = prio_q;
        end
      end
    end
  end

  // Store: hand the image out, marking which commands may be rewritten
  always_comb
  begin
    store_d   = i_store && loaded_q;
    st_prio_d = st_prio_q;
    st_stk_d  = st_stk_q;
    st_mask_d = st_mask_q;
    if (store_d)
    begin
      // Host must have written values it wants kept
      st_prio_d = prio_q;
      st_stk_d  = stk_q;
      st_mask_d = written_q | i_func_written;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      loaded_q  <= 1'b0;
      stk_q     <= scfg_pkg::STACK_RESET;
      prio_q    <= scfg_pkg::PRIO_RESET;
      written_q <= '0;
      rsp_q     <= '0;
      store_q   <= 1'b0;
      st_prio_q <= scfg_pkg::PRIO_RESET;
      st_stk_q  <= scfg_pkg::STACK_RESET;
      st_mask_q <= '0;
      use_q     <= '0;
      role_q    <= scfg_pkg::STACK_PRIMARY;
    end
    else
    begin
      loaded_q  <= loaded_d;
      stk_q     <= stk_d;
      prio_q    <= prio_d;
      written_q <= written_d;
      rsp_q     <= rsp_d;
      store_q   <= store_d;
      st_prio_q <= st_prio_d;
      st_stk_q  <= st_stk_d;
      st_mask_q <= st_mask_d;
      use_q     <= use_d;
      role_q    <= role_d;
    end
  end

  assign o_rsp            = rsp_q;
  assign o_ready          = loaded_q;
  assign o_use_strap      = use_q;
  assign o_stack_role     = role_q;
  assign o_store_valid    = store_q;
  assign o_store_priority = st_prio_q;
  assign o_store_stack    = st_stk_q;
  assign o_store_mask     = st_mask_q;

  // Checks on the driven registers and outputs
  AST_STK_UPPER: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    take && hit_stack && !i_req.word && !i_req.write
    |=> o_rsp.ack && o_rsp.data[7:4] == strap)
    else $error("stack upper nibble not strap copy");

  AST_STK_FIELDS: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    take && hit_stack && !i_req.word && !i_req.write
    |=> o_rsp.data[3:0] == $past(stk_q))
    else $error("stack fields not returned in place");

  // Low nibble holds position above count, swapped against the strap copy
  AST_STK_LOAD: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    $rose(loaded_q) |-> stk_q ==
      (act[scfg_pkg::FUNC_BIT[scfg_pkg::F_STACK]]
       ? {strap.stack_position, strap.stack_count}
       : scfg_pkg::STACK_PRIMARY))
    else $error("stack fields not loaded from straps");

  AST_STK_ROLE: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    loaded_q && !act[scfg_pkg::FUNC_BIT[scfg_pkg::F_STACK]] ##1 loaded_q
    |-> o_stack_role == scfg_pkg::STACK_PRIMARY)
    else $error("role not primary single phase");

  AST_BYTE_ONLY: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    take && hit_stack && i_req.word |=> o_rsp.valid && !o_rsp.ack)
    else $error("word access to stack accepted");

  AST_PRIO_WR: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    take && hit_prio && i_req.word && i_req.write
    |=> prio_q == ($past(i_req.data) & scfg_pkg::PRIO_MASK))
    else $error("priority write not stored");

  // Watches the answer itself, so a leak through the read path shows
  AST_PRIO_ZERO: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    o_rsp.valid |-> (o_rsp.data[14:12] == 3'b000))
    else $error("unsupported priority bits set");

  AST_ACT_HOLD: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    loaded_q |=> $stable(act))
    else $error("active priority changed before power cycle");

  AST_SEL_SS: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    loaded_q ##1 loaded_q
    |-> o_use_strap[1] == act[11] && o_use_strap[2] == act[10])
    else $error("soft-start or fault selection wrong");

  AST_SEL_ADDR: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    loaded_q ##1 loaded_q |-> o_use_strap[3] == act[9]
    && o_use_strap[8] == act[2])
    else $error("address or limit selection wrong");

  AST_VOUT_STRAP_CHOICE_EXT: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    i_ext_divider |=> !o_use_strap[9])
    else $error("vout strap used with external divider");

  AST_STORE_MASK: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    i_store && loaded_q |=> o_store_valid
    && o_store_mask == $past(written_q | i_func_written))
    else $error("store mask does not follow written commands");

  AST_LATCH_ONCE: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    latch_done |=> $stable(strap))
    else $error("strap result recaptured");

endmodule // scfg_top

/* File: tb/scfg_host.sv */
// Host model issuing decoded configuration commands and stores
`timescale 1ns/1ps
module scfg_host
(
  input  wire logic                i_clock,
  input  wire scfg_pkg::scfg_rsp_t i_rsp,
  output scfg_pkg::scfg_req_t      o_req,
  output logic                     o_store,
  output logic [9:0]               o_func_written
);
  // Quiet bus at time zero
  initial
  begin
    o_req = '0;
    o_store = 1'b0;
    o_func_written = 10'h000;
  end

  // One request, held to its taking edge, answer read in the next cycle
  task automatic xfer(input logic wr, input logic wd, input logic [7:0] c,
                      input logic [15:0] d, output scfg_pkg::scfg_rsp_t rsp);
    @(negedge i_clock);
    o_req = {1'b1, wr, wd, c, d};
    @(negedge i_clock);
    rsp = i_rsp;
    o_req.valid = 1'b0;
    // Released lines flip so a stale value never looks live
    o_req.data = ~d;
    o_req.code = ~c;
  endtask

  // Host writes wanted values first, then asks for a store
  task automatic store(input logic [9:0] written);
    @(negedge i_clock);
    o_func_written = written;
    @(negedge i_clock);
    o_func_written = 10'h000;
    o_store = 1'b1;
    @(negedge i_clock);
    o_store = 1'b0;
  endtask
endmodule // scfg_host

/* File: tb/tb.sv */
// Self-checking bench for the stack and strap priority config block
`timescale 1ns/1ps
module tb;
  localparam logic [7:0]  SK = scfg_pkg::CMD_STACK;
  localparam logic [7:0]  PR = scfg_pkg::CMD_PRIORITY;
  localparam logic [15:0] M  = scfg_pkg::PRIO_MASK;
  logic                  i_clock = 1'b0;
  logic                  i_rst_n = 1'b0;
  logic                  ext = 1'b0;
  logic [15:0]           nvm = 16'h0000;
  logic [15:0]           x, nxt, sp, ex;
  logic [9:0]            w, us, sm, fw, u;
  logic [3:0]            y, role, ss, z;
  logic                  rdy, sv, stb;
  scfg_pkg::scfg_strap_t st = '0;
  scfg_pkg::scfg_strap_t s0;
  scfg_pkg::scfg_req_t   req;
  scfg_pkg::scfg_rsp_t   rsp, r;
  int                    mismatches = 0;
  int                    num_checks = 0;
  int                    seed = 18;

  // Free-running 100 MHz clock
  always #5 i_clock = ~i_clock;

  scfg_host host (.i_clock(i_clock), .i_rsp(rsp), .o_req(req),
                  .o_store(stb), .o_func_written(fw));
  scfg_top dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_strap(st),
                .i_nvm_priority(nvm), .i_ext_divider(ext), .i_req(req),
                .i_store(stb), .i_func_written(fw), .o_rsp(rsp),
                .o_ready(rdy), .o_use_strap(us), .o_stack_role(role),
                .o_store_valid(sv), .o_store_priority(sp),
                .o_store_stack(ss), .o_store_mask(sm));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string n, input logic [15:0] s,
                       input logic [15:0] e);
    num_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  // Expected strap selection from a power-on priority word
  function automatic logic [9:0] use_of(input logic [15:0] p, input logic e);
    for (int f = 0; f < scfg_pkg::FUNC_N; f++)
      use_of[f] = p[scfg_pkg::FUNC_BIT[f]];
    use_of[scfg_pkg::F_VOUT_SEL] &= ~e;
  endfunction

  task automatic cmd(input logic wr, input logic wd, input logic [7:0] c,
                     input logic [15:0] d, input logic a,
                     input logic [15:0] e);
    host.xfer(wr, wd, c, d, r);
    check("rsp valid", r.valid, 1'b1);
    check("rsp ack", r.ack, a);
    check("rsp data", r.data, e);
  endtask

  // Power cycles with corner and random images, straps, divider choice
  initial
  begin
    for (int it = 0; it < 4; it++)
    begin
      @(negedge i_clock);
      i_rst_n = 1'b0;
      st  = 4'($random(seed));
      // Divider on with a strap-ruled vout, then off, then random
      ext = (it == 3) ? 1'($random(seed)) : (it == 0);
      nvm = (it == 0) ? 16'hffff : (it == 1) ? 16'h0000 :
            (it == 2) ? nxt : 16'($random(seed));
      repeat (12) @(negedge i_clock);
      i_rst_n = 1'b1;
      for (int n = 0; n < 8 && rdy !== 1'b1; n++)
        @(negedge i_clock);
      if (rdy !== 1'b1)
      begin
        mismatches++;
        $display("BAD o_ready expected 1 seen %b", rdy);
        print_verdict();
      end
      // Later strap changes must not reach the latched copy
      s0 = st;
      st = ~s0;
      y  = nvm[15] ? s0 : 4'h0;
      // Register low nibble is position then count, opposite to the straps
      z  = nvm[15] ? {s0.stack_position, s0.stack_count} : 4'h0;
      u  = use_of(nvm, ext);
      ex = {8'h00, s0, z};
      check("use", us, u);
      check("role", role, y);
      cmd(1'b0, 1'b0, SK, 16'h0, 1'b1, ex);
      cmd(1'b0, 1'b1, PR, 16'h0, 1'b1, nvm & M);
      x = 16'($random(seed)) | {it == 1, 14'h0, it == 1};
      cmd(1'b1, 1'b1, PR, x, 1'b1, 16'h0);
      cmd(1'b0, 1'b1, PR, 16'h0, 1'b1, x & M);
      check("use held", us, u);
      check("role held", role, y);
      y = 4'($random(seed));
      cmd(1'b1, 1'b0, SK, {12'h0, y}, 1'b1, 16'h0);
      cmd(1'b0, 1'b0, SK, 16'h0, 1'b1, {8'h00, s0, y});
      cmd(1'b1, 1'b1, SK, 16'hffff, 1'b0, 16'h0);
      cmd(1'b1, 1'b0, PR, 16'hffff, 1'b0, 16'h0);
      cmd(1'b1, 1'b1, 8'hd7, 16'hffff, 1'b0, 16'h0);
      cmd(1'b0, 1'b1, PR, 16'h0, 1'b1, x & M);
      w = 10'($random(seed));
      host.store(w);
      check("store valid", sv, 1'b1);
      check("store prio", sp, x & M);
      check("store stack", ss, y);
      check("store mask", sm, w | 10'h001);
      nxt = x & M;
      $display("test %0d done", it);
    end
    print_verdict();
  end
endmodule // tb
